// ===== common/operand_decoder_pkg.sv
`default_nettype none
package operand_decoder_pkg;
  // instruction word layout
  localparam int WORD_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_COUNT = 16;
  localparam int HI_FIELD_LSB = 8; // bits 11..8
  localparam int MID_FIELD_LSB = 4; // bits 7..4
  localparam int LO_FIELD_LSB = 0; // bits 3..0
  localparam int IMM_LSB = 0; // bits 7..0
  localparam logic [3:0] REG_ZERO_IDX = 4'h0;
  // address step per access size
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam int TRAP_SHIFT = 2; // vector offset is imm times four

  typedef enum logic [3:0] {
    FMT_ZERO, FMT_N, FMT_M, FMT_NM, FMT_MD, FMT_ND4, FMT_NMD, FMT_I, FMT_NI
  } fmt_e;

  typedef enum logic [2:0] {
    MD_NONE, MD_DIRECT, MD_INDIRECT, MD_POSTINC, MD_PREDEC, MD_INDEX_R0, MD_DISP, MD_PC_REL
  } mode_e;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_e;

  typedef enum logic [1:0] {IMM_NONE, IMM_ZEXT, IMM_SEXT, IMM_TRAP} imm_e;

  // control word from the opcode decoder
  typedef struct packed {
    fmt_e fmt;
    mode_e src_mode;
    mode_e dst_mode;
    size_e size;
    imm_e imm_kind;
    logic mac;
  } decode_s;

  // write port from the execution stage
  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [31:0] data;
  } reg_write_s;

  // decoded operands handed to execution
  typedef struct packed {
    logic valid;
    logic src_sel;
    logic [3:0] src_idx;
    logic [31:0] src_val;
    logic src_addr_valid;
    logic [31:0] src_addr;
    logic dst_sel;
    logic [3:0] dst_idx;
    logic [31:0] dst_val;
    logic dst_addr_valid;
    logic [31:0] dst_addr;
    logic target_valid;
    logic [31:0] target;
    logic imm_valid;
    logic [31:0] imm;
    logic to_accumulator;
  } operand_s;
endpackage : operand_decoder_pkg
`default_nettype wire

// ===== rtl/operand_address_decoder.sv
// Behaviour
// RQ1 - direct mode: register contents, no address
// RQ2 - indirect: address equals register, register kept
// RQ3 - post-increment: old value addresses, add 1/2/4
// RQ4 - pre-decrement: subtract 1/2/4, use and store
// RQ5 - register branch target is PC plus register
// RQ6 - logic and test immediates zero-extended
// RQ7 - move, add, compare immediates sign-extended
// RQ8 - trap immediate zero-extended, times four
// RQ9 - n format: bits 11..8 destination register
// RQ10 - m format: bits 11..8 source register
// RQ11 - nm format: destination 11..8, source 7..4
// RQ12 - nd4 format: zero register data, base 7..4
// RQ13 - displacement formats: disp in bits 3..0
// RQ14 - zero format selects no registers
// RQ15 - every instruction word is sixteen bits
// RQ16 - multiply-accumulate: destination field post-increments too
// RQ17 - sixteen general registers, register zero implicit
`timescale 1ns/1ns
`default_nettype none
module operand_address_decoder
  import operand_decoder_pkg::*;
#(
  parameter int NREGS = REG_COUNT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [WORD_W-1:0] in_word,
  input wire decode_s in_ctl,
  input wire logic [DATA_W-1:0] pc,
  input wire reg_write_s wb,
  output operand_s out_q
);

  // step for the access size
  function automatic logic [31:0] size_step(input size_e sz);
    case (sz)
      SZ_BYTE: size_step = STEP_BYTE;
      SZ_WORD: size_step = STEP_WORD;
      SZ_LONG: size_step = STEP_LONG;
      default: size_step = STEP_LONG;
    endcase
  endfunction : size_step

  // effective address for one operand
  function automatic logic [31:0] eff_addr(input mode_e md, input logic [31:0] base,
      input logic [31:0] r0, input logic [3:0] disp, input size_e sz, input logic [31:0] pcv);
    case (md)
      MD_PREDEC: eff_addr = base - size_step(sz);
      MD_INDEX_R0: eff_addr = base + r0;
      MD_DISP: eff_addr = base + ({28'h0000000, disp} * size_step(sz));
      MD_PC_REL: eff_addr = pcv + base;
      default: eff_addr = base; // indirect, post-increment
    endcase
  endfunction : eff_addr

  // modes that reach memory
  function automatic logic is_mem(input mode_e md);
    is_mem = (md == MD_INDIRECT) || (md == MD_POSTINC) || (md == MD_PREDEC) ||
             (md == MD_INDEX_R0) || (md == MD_DISP);
  endfunction : is_mem

  // modes that write the base register back
  function automatic logic is_upd(input mode_e md);
    is_upd = (md == MD_POSTINC) || (md == MD_PREDEC);
  endfunction : is_upd

  logic [31:0] regs_q [NREGS]; // general registers
  logic [31:0] regs_d [NREGS];
  operand_s out_d;

  // field extraction; every word is a single 16-bit unit
  logic [3:0] hi_f, mid_f, lo_f; // RQ15
  logic [7:0] imm8;
  logic [3:0] src_idx, dst_idx;
  logic src_sel, dst_sel;
  mode_e src_md, dst_md;
  logic [31:0] rd_src, rd_dst, rd_r0;
  logic [31:0] step;

  assign hi_f = in_word[HI_FIELD_LSB +: 4];
  assign mid_f = in_word[MID_FIELD_LSB +: 4];
  assign lo_f = in_word[LO_FIELD_LSB +: 4];
  assign imm8 = in_word[IMM_LSB +: 8];
  assign step = size_step(in_ctl.size);
  assign rd_src = regs_q[src_idx];
  assign rd_dst = regs_q[dst_idx];
  assign rd_r0 = regs_q[REG_ZERO_IDX];

  // register selection per format
  always_comb begin
    src_idx = REG_ZERO_IDX;
    dst_idx = REG_ZERO_IDX;
    src_sel = 1'b0;
    dst_sel = 1'b0;
    src_md = in_ctl.src_mode;
    dst_md = in_ctl.dst_mode;
    case (in_ctl.fmt)
      FMT_ZERO: begin
        src_md = MD_NONE; // RQ14
        dst_md = MD_NONE; // RQ14
      end
      FMT_N: begin
        dst_idx = hi_f; // RQ9
        dst_sel = 1'b1;
        src_md = MD_NONE; // source is an implied control register
      end
      FMT_M: begin
        src_idx = hi_f; // RQ10
        src_sel = 1'b1;
        dst_md = MD_NONE;
      end
      FMT_NM: begin
        dst_idx = hi_f; // RQ11
        src_idx = mid_f; // RQ11
        dst_sel = 1'b1;
        src_sel = 1'b1;
        if (in_ctl.mac) begin
          src_md = MD_POSTINC; // RQ16
          dst_md = MD_POSTINC; // RQ16
        end
      end
      FMT_MD: begin
        src_idx = mid_f; // RQ13
        src_sel = 1'b1;
        dst_idx = REG_ZERO_IDX; // RQ17
        dst_sel = 1'b1;
      end
      FMT_ND4: begin
        src_idx = REG_ZERO_IDX; // RQ12
        src_sel = 1'b1;
        dst_idx = mid_f; // RQ12
        dst_sel = 1'b1;
      end
      FMT_NMD: begin
        src_idx = mid_f; // RQ13
        dst_idx = hi_f; // RQ13
        src_sel = 1'b1;
        dst_sel = 1'b1;
      end
      FMT_I: begin
        dst_idx = REG_ZERO_IDX; // RQ17
        dst_sel = (in_ctl.dst_mode != MD_NONE);
        src_md = MD_NONE;
      end
      FMT_NI: begin
        dst_idx = hi_f;
        dst_sel = 1'b1;
        src_md = MD_NONE;
      end
      default: begin
        src_md = MD_NONE;
        dst_md = MD_NONE;
      end
    endcase
    // a field with no mode names no register
    if (src_md == MD_NONE) src_sel = 1'b0;
    if (dst_md == MD_NONE) dst_sel = 1'b0;
  end

  // operand, address, immediate and register update
  always_comb begin
    for (int i = 0; i < NREGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    out_d = '0;
    out_d.valid = in_valid;
    out_d.src_sel = in_valid && src_sel;
    out_d.dst_sel = in_valid && dst_sel;
    out_d.src_idx = src_idx;
    out_d.dst_idx = dst_idx;
    out_d.src_val = rd_src; // RQ1
    out_d.dst_val = rd_dst; // RQ1
    out_d.src_addr = eff_addr(src_md, rd_src, rd_r0, lo_f, in_ctl.size, pc); // RQ2
    out_d.dst_addr = eff_addr(dst_md, rd_dst, rd_r0, lo_f, in_ctl.size, pc); // RQ2
    out_d.src_addr_valid = in_valid && src_sel && is_mem(src_md);
    out_d.dst_addr_valid = in_valid && dst_sel && is_mem(dst_md);
    out_d.target_valid = in_valid && src_sel && (src_md == MD_PC_REL); // RQ5
    out_d.target = pc + rd_src; // RQ5
    out_d.to_accumulator = in_valid && in_ctl.mac && (in_ctl.fmt == FMT_NM); // RQ16
    out_d.imm_valid = in_valid && (in_ctl.imm_kind != IMM_NONE);
    case (in_ctl.imm_kind)
      IMM_ZEXT: out_d.imm = {24'h000000, imm8}; // RQ6
      IMM_SEXT: out_d.imm = {{24{imm8[7]}}, imm8}; // RQ7
      IMM_TRAP: out_d.imm = {22'h0, imm8, 2'h0}; // RQ8
      default: out_d.imm = 32'h0000_0000;
    endcase
    // base register write-back; destination applied last
    if (in_valid && src_sel && is_upd(src_md)) begin
      regs_d[src_idx] = (src_md == MD_POSTINC) ? rd_src + step : rd_src - step; // RQ3 RQ4
    end
    if (in_valid && dst_sel && is_upd(dst_md)) begin
      regs_d[dst_idx] = (dst_md == MD_POSTINC) ? rd_dst + step : rd_dst - step; // RQ3 RQ4
    end
    // execution result wins over an address update on the same register
    if (wb.en) begin
      regs_d[wb.idx] = wb.data; // RQ17
    end
  end

  // register everything
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NREGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
      out_q <= '0;
    end else begin
      for (int i = 0; i < NREGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
      out_q <= out_d;
    end
  end

  // checks
  logic no_wb_src, no_wb_dst;
  assign no_wb_src = !(wb.en && wb.idx == src_idx);
  assign no_wb_dst = !(wb.en && wb.idx == dst_idx);

  sequence s_postinc_src;
    in_valid && src_sel && src_md == MD_POSTINC && no_wb_src &&
      !(dst_sel && is_upd(dst_md) && dst_idx == src_idx);
  endsequence
  sequence s_predec_dst;
    in_valid && dst_sel && dst_md == MD_PREDEC && no_wb_dst;
  endsequence

  direct_no_addr_a: assert property (@(posedge clk) disable iff (!rstn) // RQ1
    in_valid && src_sel && src_md == MD_DIRECT |=>
      !out_q.src_addr_valid && out_q.src_val == $past(rd_src))
    else $error("direct operand produced an address");
  // a source update on the same register legally moves it, so that case is left out
  indirect_keep_a: assert property (@(posedge clk) disable iff (!rstn) // RQ2
    in_valid && dst_sel && dst_md == MD_INDIRECT && no_wb_dst &&
      !(src_sel && is_upd(src_md) && src_idx == dst_idx) |=>
      out_q.dst_addr == $past(rd_dst) && regs_q[out_q.dst_idx] == $past(rd_dst))
    else $error("indirect address or register wrong");
  postinc_step_a: assert property (@(posedge clk) disable iff (!rstn) // RQ3
    s_postinc_src |=> out_q.src_addr == $past(rd_src) &&
      regs_q[out_q.src_idx] == $past(rd_src) + $past(step))
    else $error("post-increment wrong");
  predec_step_a: assert property (@(posedge clk) disable iff (!rstn) // RQ4
    s_predec_dst |=> out_q.dst_addr == $past(rd_dst) - $past(step) &&
      regs_q[out_q.dst_idx] == out_q.dst_addr)
    else $error("pre-decrement wrong");
  pc_target_a: assert property (@(posedge clk) disable iff (!rstn) // RQ5
    in_valid && src_sel && src_md == MD_PC_REL |=>
      out_q.target_valid && out_q.target == $past(pc) + $past(rd_src))
    else $error("register branch target wrong");
  zext_imm_a: assert property (@(posedge clk) disable iff (!rstn) // RQ6
    in_valid && in_ctl.imm_kind == IMM_ZEXT |=> out_q.imm == {24'h000000, $past(imm8)})
    else $error("zero-extended immediate wrong");
  sext_imm_a: assert property (@(posedge clk) disable iff (!rstn) // RQ7
    in_valid && in_ctl.imm_kind == IMM_SEXT |=>
      $signed(out_q.imm) == $signed($past(imm8)))
    else $error("sign-extended immediate wrong");
  trap_imm_a: assert property (@(posedge clk) disable iff (!rstn) // RQ8
    in_valid && in_ctl.imm_kind == IMM_TRAP |=> out_q.imm == 32'($past(imm8)) * 32'h4)
    else $error("trap vector offset wrong");
  nop_no_sel_a: assert property (@(posedge clk) disable iff (!rstn) // RQ14
    in_valid && in_ctl.fmt == FMT_ZERO |=> out_q.valid && !out_q.src_sel &&
      !out_q.dst_sel && !out_q.src_addr_valid && !out_q.dst_addr_valid)
    else $error("zero format selected a register");
  disp_addr_a: assert property (@(posedge clk) disable iff (!rstn) // RQ13
    in_valid && in_ctl.fmt == FMT_NMD && dst_md == MD_DISP |=>
      out_q.dst_idx == $past(hi_f) &&
      out_q.dst_addr == $past(rd_dst) + 32'($past(lo_f)) * $past(step))
    else $error("displacement address wrong");
  index_addr_a: assert property (@(posedge clk) disable iff (!rstn) // RQ17
    in_valid && dst_sel && dst_md == MD_INDEX_R0 |=>
      out_q.dst_addr_valid && out_q.dst_addr == $past(rd_dst) + $past(rd_r0))
    else $error("indexed address wrong");
  mac_both_a: assert property (@(posedge clk) disable iff (!rstn) // RQ16
    in_valid && in_ctl.mac && in_ctl.fmt == FMT_NM |=>
      out_q.to_accumulator && out_q.src_addr_valid && out_q.dst_addr_valid)
    else $error("multiply-accumulate operands wrong");

endmodule : operand_address_decoder
`default_nettype wire

// ===== testbench/operand_address_decoder_bench.sv
`timescale 1ns/1ns
`default_nettype none
module operand_address_decoder_bench;
  import operand_decoder_pkg::*;
  localparam logic [31:0] PCV = 32'h0000_1000; // pc seen by every word
  logic clk;
  logic rstn;
  logic in_valid;
  logic [WORD_W-1:0] in_word;
  decode_s in_ctl;
  logic [DATA_W-1:0] pc;
  reg_write_s wb;
  operand_s out_q;
  int err_count;
  int compares;
  operand_address_decoder #(.NREGS(REG_COUNT)) dut_u (.clk(clk), .rstn(rstn),
    .in_valid(in_valid), .in_word(in_word), .in_ctl(in_ctl), .pc(pc), .wb(wb), .out_q(out_q));
  // free-running core clock
  always #4 clk = ~clk;
  task automatic wrap_up();
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // wide values
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v
  // single flags
  task automatic chk_f(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_f
  // preload a register through write-back; en drops one edge later
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    @(posedge clk);
    wb <= '{1'b1, i, d};
    @(posedge clk);
    wb <= '{1'b0, 4'h0, 32'h0};
  endtask : wr
  // one word, result sampled just after the answering edge
  task automatic op(input logic [15:0] w, input fmt_e f, input mode_e s, input mode_e d,
                    input size_e z, input imm_e k, input logic m);
    @(posedge clk);
    in_valid <= 1'b1;
    in_word <= w;
    in_ctl <= '{f, s, d, z, k, m};
    @(posedge clk);
    in_valid <= 1'b0;
    #1;
    chk_f(out_q.valid, 1'b1);
  endtask : op
  task automatic t_direct();
    op(16'h6130, FMT_NM, MD_DIRECT, MD_DIRECT, SZ_LONG, IMM_NONE, 1'b0);
    chk_v(out_q.dst_val, REG_RESET);
    wr(4'h3, 32'h1234_5678);
    wr(4'h5, 32'h0000_0200);
    op(16'h6530, FMT_NM, MD_DIRECT, MD_INDIRECT, SZ_LONG, IMM_NONE, 1'b0);
    chk_v(out_q.src_val, 32'h1234_5678);
    chk_f(out_q.src_addr_valid, 1'b0);
    chk_v(32'(out_q.src_idx), 32'h3);
    chk_v(32'(out_q.dst_idx), 32'h5);
    chk_v(out_q.dst_addr, 32'h0000_0200);
    chk_f(out_q.dst_addr_valid, 1'b1);
    op(16'h6530, FMT_NM, MD_DIRECT, MD_DIRECT, SZ_LONG, IMM_NONE, 1'b0);
    chk_v(out_q.dst_val, 32'h0000_0200);
  endtask : t_direct
  // every access size, post-increment then pre-decrement on one register
  task automatic t_step();
    logic [31:0] st;
    for (int i = 0; i < 3; i++) begin
      st = (i == 0) ? STEP_BYTE : (i == 1) ? STEP_WORD : STEP_LONG;
      wr(4'h2, 32'h0000_1000);
      op(16'h4200, FMT_M, MD_POSTINC, MD_NONE, size_e'(i), IMM_NONE, 1'b0);
      chk_v(out_q.src_addr, 32'h0000_1000);
      chk_v(32'(out_q.src_idx), 32'h2);
      op(16'h4200, FMT_M, MD_DIRECT, MD_NONE, size_e'(i), IMM_NONE, 1'b0);
      chk_v(out_q.src_val, 32'h0000_1000 + st);
      op(16'h4200, FMT_N, MD_NONE, MD_PREDEC, size_e'(i), IMM_NONE, 1'b0);
      chk_v(out_q.dst_addr, 32'h0000_1000);
      chk_v(32'(out_q.dst_idx), 32'h2);
      op(16'h4200, FMT_N, MD_NONE, MD_DIRECT, size_e'(i), IMM_NONE, 1'b0);
      chk_v(out_q.dst_val, 32'h0000_1000);
    end
  endtask : t_step
  task automatic t_pcrel();
    wr(4'h6, 32'h0000_0040);
    op(16'h0623, FMT_M, MD_PC_REL, MD_NONE, SZ_LONG, IMM_NONE, 1'b0);
    chk_v(out_q.target, PCV + 32'h0000_0040);
    chk_f(out_q.target_valid, 1'b1);
  endtask : t_pcrel
  // top bit of the byte set, so the extension kind shows
  task automatic t_imm();
    op(16'hC880, FMT_I, MD_NONE, MD_NONE, SZ_LONG, IMM_ZEXT, 1'b0);
    chk_v(out_q.imm, 32'h0000_0080);
    op(16'h7780, FMT_NI, MD_NONE, MD_DIRECT, SZ_LONG, IMM_SEXT, 1'b0);
    chk_v(out_q.imm, 32'hFFFF_FF80);
    chk_v(32'(out_q.dst_idx), 32'h7);
    op(16'hC3FF, FMT_I, MD_NONE, MD_NONE, SZ_LONG, IMM_TRAP, 1'b0);
    chk_v(out_q.imm, 32'h0000_03FC);
    chk_f(out_q.imm_valid, 1'b1);
  endtask : t_imm
  // displacement is scaled by access size
  task automatic t_disp();
    wr(4'h0, 32'h0000_00AA);
    wr(4'h7, 32'h0000_0100);
    op(16'h8473, FMT_MD, MD_DISP, MD_DIRECT, SZ_WORD, IMM_NONE, 1'b0);
    chk_v(out_q.src_addr, 32'h0000_0106);
    chk_v(32'(out_q.dst_idx), 32'h0);
    op(16'h8075, FMT_ND4, MD_DIRECT, MD_DISP, SZ_LONG, IMM_NONE, 1'b0);
    chk_v(out_q.src_val, 32'h0000_00AA);
    chk_v(out_q.dst_addr, 32'h0000_0114);
  endtask : t_disp
  // modes offered on purpose; the format must still select nothing
  task automatic t_zero();
    op(16'h0009, FMT_ZERO, MD_DIRECT, MD_DIRECT, SZ_LONG, IMM_NONE, 1'b0);
    chk_f(out_q.src_sel, 1'b0);
    chk_f(out_q.dst_sel, 1'b0);
  endtask : t_zero
  task automatic t_mac();
    wr(4'h8, 32'h0000_0200);
    wr(4'h9, 32'h0000_0300);
    op(16'h489F, FMT_NM, MD_DIRECT, MD_DIRECT, SZ_WORD, IMM_NONE, 1'b1);
    chk_f(out_q.to_accumulator, 1'b1);
    chk_v(out_q.dst_addr, 32'h0000_0200);
    chk_v(out_q.src_addr, 32'h0000_0300);
    op(16'h4989, FMT_NM, MD_DIRECT, MD_DIRECT, SZ_LONG, IMM_NONE, 1'b0);
    chk_v(out_q.dst_val, 32'h0000_0302);
    chk_v(out_q.src_val, 32'h0000_0202);
  endtask : t_mac
  // indexed and displacement destinations, then the result drops after one cycle
  task automatic t_index();
    wr(4'h0, 32'h0000_0010);
    wr(4'h4, 32'h0000_0400);
    wr(4'h5, 32'h0000_0500);
    op(16'h0456, FMT_NM, MD_DIRECT, MD_INDEX_R0, SZ_LONG, IMM_NONE, 1'b0);
    chk_v(out_q.dst_addr, 32'h0000_0410);
    chk_f(out_q.dst_addr_valid, 1'b1);
    chk_f(out_q.src_sel, 1'b1);
    chk_f(out_q.dst_sel, 1'b1);
    chk_f(out_q.target_valid, 1'b0);
    chk_f(out_q.to_accumulator, 1'b0);
    op(16'h1453, FMT_NMD, MD_DIRECT, MD_DISP, SZ_LONG, IMM_NONE, 1'b0);
    chk_v(out_q.dst_addr, 32'h0000_040C);
    chk_v(out_q.src_val, 32'h0000_0500);
    chk_v(32'(out_q.dst_idx), 32'h4);
    @(posedge clk);
    #1;
    chk_f(out_q.valid, 1'b0);
  endtask : t_index
  // reset in mid-run clears the general registers
  task automatic t_reset();
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    op(16'h6450, FMT_NM, MD_DIRECT, MD_DIRECT, SZ_LONG, IMM_NONE, 1'b0);
    chk_v(out_q.dst_val, REG_RESET);
    chk_v(out_q.src_val, REG_RESET);
  endtask : t_reset
  // main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    in_valid = 1'b0;
    in_word = '0;
    in_ctl = '0;
    pc = PCV;
    wb = '0;
    err_count = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_direct();
    t_step();
    t_pcrel();
    t_imm();
    t_disp();
    t_zero();
    t_mac();
    t_index();
    t_reset();
    wrap_up();
  end
  // hang guard, well past the hundred or so cycles of the run
  initial begin
    #(8 * 5000);
    err_count++;
    wrap_up();
  end
endmodule : operand_address_decoder_bench
`default_nettype wire
